/* src/ddsc_top.sv */
// serial command port, command decoder and register bus of the dual converter
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - a word starts only on the falling edge of select
// - while select low, each serial clock fall shifts one bit, msb first
// - after sixteen bits the word acts at once, select may stay low
// - select rising before the word is complete discards it, nothing changes
// - serial clock may idle high or low, only falling edges shift
// - word is four command bits, ten code bits, two suffix bits
// - code is unsigned straight binary, zero scale to full scale
// - each channel has input and output register, output follows output register
// - 0000 and 0001 write code straight to output register of A or B
// - 0100 and 0101 load input register of A or B only
// - 1000 and 1001 copy input register to output register of A or B
// - 1100 writes code into both input and both output registers
// - 1101 loads both input registers, outputs unchanged
// - 1110 copies both input registers to output registers together
// - 1111 is power control, word bits 4 to 2 select A, B or both
// - suffix 00 wakes, 01 floats, 10 one kilohm, 11 hundred kilohm
// - reset clears all input and output registers and powers both channels down at 100k
// - after sixteen bits clock and data are ignored until select falls
// - power changes never touch input or output registers
module ddsc_top
    import ddsc_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // register bus
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [ddsc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                  wvalid,
    output logic                       wready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    output logic                       bvalid,
    input  wire logic                  bready,
    output logic [1:0]                 bresp,
    input  wire logic                  arvalid,
    output logic                       arready,
    input  wire logic [ddsc_pkg::ADDR_W-1:0] araddr,
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    // serial pins
    input  wire logic                  select_n,
    input  wire logic                  serial_clk,
    input  wire logic                  serial_din,
    // converter side
    output logic [ddsc_pkg::CODE_W-1:0] analog_output_a,
    output logic [ddsc_pkg::CODE_W-1:0] analog_output_b,
    output logic [1:0]                 power_mode_a,
    output logic [1:0]                 power_mode_b
);
    import ddsc_pkg::*;

    function automatic logic cmd_pair(input logic [3:0] c, input logic [3:0] base);
        cmd_pair = (c[3:1] == base[3:1]);
    endfunction

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_CHAN_A) || (a == OFS_CHAN_B);
    endfunction

    // ************************************************
    // pin synchronisers and edge finding
    // ************************************************
    logic              cs_m, cs_s, cs_q;
    logic              sck_m, sck_s, sck_q;
    logic              din_m, din_s, din_q;
    ddsc_frame_e       state, next_state;
    logic [CNT_W-1:0]  count;
    logic [14:0]       shift;
    logic              serial_en;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {cs_m, cs_s, cs_q} <= 3'h7;
            {sck_m, sck_s, sck_q} <= 3'h0;
            {din_m, din_s, din_q} <= 3'h0;
        end else begin
            {cs_m, cs_s, cs_q} <= {select_n, cs_m, cs_s};
            {sck_m, sck_s, sck_q} <= {serial_clk, sck_m, sck_s};
            {din_m, din_s, din_q} <= {serial_din, din_m, din_s};
        end
    end

    wire cs_fall   = cs_q & ~cs_s;
    wire sck_fall  = sck_q & ~sck_s;
    wire sck_rise  = ~sck_q & sck_s;
    // din_q is data seen while the clock was still high, safe for zero hold
    wire bit_take  = (state == frm_shift) & ~cs_s & sck_fall;
    wire exec      = bit_take & (count == LAST_BIT);

    // ************************************************
    // word fields
    // ************************************************
    wire [15:0]       word = {shift, din_q};
    wire [3:0]        cmd  = word[15:12];
    wire [CODE_W-1:0] code = word[11:2];
    wire [2:0]        tgt  = word[4:2];
    wire [1:0]        sfx  = word[1:0];

    // ************************************************
    // frame state machine
    // ************************************************
    always_comb begin
        next_state = state;
        case (state)
            frm_idle: begin
                if (cs_fall && serial_en) begin
                    next_state = frm_shift;
                end
            end
            frm_shift: begin
                if (cs_s || exec) begin
                    next_state = frm_idle;
                end
            end
            default: next_state = frm_idle;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= frm_idle;
            count <= '0;
            shift <= '0;
        end else begin
            state <= next_state;
            if (next_state == frm_idle) begin
                count <= '0;
            end else if (bit_take) begin
                count <= count + 1'b1;
            end
            if (bit_take) begin
                shift <= {shift[13:0], din_q};
            end
        end
    end

    // ************************************************
    // per channel registers
    // ************************************************
    logic [CODE_W-1:0] in_reg  [2];
    logic [CODE_W-1:0] out_reg [2];
    logic [1:0]        pwr     [2];

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        localparam logic       SEL = 1'(ch);
        localparam logic [2:0] TGT = (ch == 0) ? TGT_A : TGT_B;
        wire one    = (cmd[0] == SEL);
        wire wr_dir = exec & ((cmd_pair(cmd, CMD_DIR_A) & one) | (cmd == CMD_DIR_AB));
        wire wr_ld  = exec & ((cmd_pair(cmd, CMD_LD_A) & one) | (cmd == CMD_LD_AB)
                              | (cmd == CMD_DIR_AB));
        wire wr_upd = exec & ((cmd_pair(cmd, CMD_UPD_A) & one) | (cmd == CMD_UPD_AB));
        wire wr_pwr = exec & (cmd == CMD_PWR) & ((tgt == TGT) | (tgt == TGT_AB));

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                in_reg[ch]  <= CODE_RST;
                out_reg[ch] <= CODE_RST;
                pwr[ch]     <= PWR_RST;
            end else begin
                if (wr_ld) begin
                    in_reg[ch] <= code;
                end
                if (wr_dir) begin
                    out_reg[ch] <= code;
                end else if (wr_upd) begin
                    out_reg[ch] <= in_reg[ch];
                end
                if (wr_pwr) begin
                    pwr[ch] <= sfx;
                end
            end
        end
    end

    assign analog_output_a = out_reg[0];
    assign analog_output_b = out_reg[1];
    assign power_mode_a    = pwr[0];
    assign power_mode_b    = pwr[1];

    // ************************************************
    // register bus slave
    // ************************************************
    logic              aw_held, w_held;
    logic [ADDR_W-1:0] aw_q;
    logic [31:0]       w_q;
    logic              strb0_q;

    assign awready = ~aw_held & ~bvalid;
    assign wready  = ~w_held & ~bvalid;
    assign arready = ~rvalid;
    wire do_write  = aw_held & w_held & ~bvalid;
    wire [31:0] rd_mux =
        (araddr == OFS_CTRL)   ? {31'h0, serial_en} :
        (araddr == OFS_STATUS) ? {27'h0, pwr[1], pwr[0], state == frm_shift} :
        (araddr == OFS_CHAN_A) ? {6'h0, in_reg[0], 6'h0, out_reg[0]} :
        (araddr == OFS_CHAN_B) ? {6'h0, in_reg[1], 6'h0, out_reg[1]} : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_q      <= '0;
            w_q       <= '0;
            strb0_q   <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            rvalid    <= 1'b0;
            rdata     <= '0;
            rresp     <= RESP_OKAY;
            serial_en <= CTRL_EN_RST;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_q    <= awaddr;
            end
            if (wvalid && wready) begin
                w_held  <= 1'b1;
                w_q     <= wdata;
                strb0_q <= wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= addr_ok(aw_q) ? RESP_OKAY : RESP_SLVERR;
                if (aw_q == OFS_CTRL && strb0_q) begin
                    serial_en <= w_q[0];
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_mux;
                rresp  <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    frame_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == frm_idle) && cs_fall && serial_en |=> (state == frm_shift) && (count == 4'h0))
        else $error("frame did not start on select fall");

    shift_msb_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_take && !exec |=> (shift[0] == $past(din_q)) && (count == $past(count) + 4'h1))
        else $error("serial bit not shifted in");

    word_act_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd == CMD_DIR_AB) |=> (out_reg[0] == $past(code)) && (out_reg[1] == $past(code))
        && (in_reg[0] == $past(code)) && (state == frm_idle))
        else $error("complete word not acted on");

    abort_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == frm_shift) && cs_s |=> (state == frm_idle) && $stable(out_reg[0])
        && $stable(out_reg[1]) && $stable(pwr[0]) && $stable(in_reg[1]))
        else $error("partial word changed state");

    rise_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sck_rise |=> $stable(count) && $stable(shift))
        else $error("rising clock edge shifted data");

    direct_a_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd == CMD_DIR_A) |=> (out_reg[0] == $past(code)) && $stable(out_reg[1]))
        else $error("direct write to A wrong");

    load_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd == 4'h5) |=> (in_reg[1] == $past(code)) && $stable(out_reg[1]) && $stable(in_reg[0]))
        else $error("load of B wrong");

    load_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd == CMD_LD_AB) |=> (in_reg[0] == $past(code)) && (in_reg[1] == $past(code))
        && $stable(out_reg[0]) && $stable(out_reg[1]))
        else $error("load of both wrong");

    copy_a_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd == CMD_UPD_A) |=> (out_reg[0] == $past(in_reg[0])) && $stable(in_reg[0]))
        else $error("copy of A wrong");

    copy_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd == CMD_UPD_AB) |=> (out_reg[0] == $past(in_reg[0])) && (out_reg[1] == $past(in_reg[1])))
        else $error("copy of both wrong");

    power_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd == CMD_PWR) && (tgt == TGT_B) |=> (pwr[1] == $past(sfx)) && $stable(pwr[0])
        && $stable(out_reg[1]) && $stable(in_reg[1]))
        else $error("power control of B wrong");

    reset_val_a: assert property (@(posedge aclk)
        !aresetn |=> (out_reg[0] == CODE_RST) && (in_reg[1] == CODE_RST) && (pwr[0] == PWR_100K)
        && (pwr[1] == PWR_100K))
        else $error("reset values wrong");

    sleep_frame_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == frm_idle) && !cs_fall |=> (state == frm_idle) && (count == 4'h0))
        else $error("frame restarted without select fall");

    bad_target_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (cmd == CMD_PWR) && (tgt != TGT_A) && (tgt != TGT_B) && (tgt != TGT_AB)
        |=> $stable(pwr[0]) && $stable(pwr[1]))
        else $error("unknown power target acted on");

    noop_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd[1] && (cmd[3:2] != 2'h3) |=> $stable(out_reg[0]) && $stable(in_reg[0])
        && $stable(out_reg[1]) && $stable(in_reg[1]) && $stable(pwr[0]))
        else $error("unlisted command changed state");

endmodule
`default_nettype wire

/* include/ddsc_pkg.sv */
// constants and types shared by the dual converter serial command block
package ddsc_pkg;

    // ************************************************
    // register map, register bus
    // ************************************************
    localparam int unsigned ADDR_W      = 5;
    localparam logic [4:0]  OFS_CTRL    = 5'h00;
    localparam logic [4:0]  OFS_STATUS  = 5'h04;
    localparam logic [4:0]  OFS_CHAN_A  = 5'h08;
    localparam logic [4:0]  OFS_CHAN_B  = 5'h0c;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ************************************************
    // serial word layout
    // ************************************************
    localparam int unsigned CODE_W   = 10;
    localparam int unsigned CNT_W    = 4;
    localparam logic [3:0]  LAST_BIT = 4'hf;
    localparam logic [9:0]  CODE_RST = 10'h000;

    // ************************************************
    // commands, power targets and power modes
    // ************************************************
    localparam logic [3:0] CMD_DIR_A  = 4'h0;
    localparam logic [3:0] CMD_LD_A   = 4'h4;
    localparam logic [3:0] CMD_UPD_A  = 4'h8;
    localparam logic [3:0] CMD_DIR_AB = 4'hc;
    localparam logic [3:0] CMD_LD_AB  = 4'hd;
    localparam logic [3:0] CMD_UPD_AB = 4'he;
    localparam logic [3:0] CMD_PWR    = 4'hf;
    localparam logic [2:0] TGT_A      = 3'h0;
    localparam logic [2:0] TGT_B      = 3'h1;
    localparam logic [2:0] TGT_AB     = 3'h4;
    localparam logic [1:0] PWR_ON     = 2'h0;
    localparam logic [1:0] PWR_FLOAT  = 2'h1;
    localparam logic [1:0] PWR_1K     = 2'h2;
    localparam logic [1:0] PWR_100K   = 2'h3;
    localparam logic [1:0] PWR_RST    = PWR_100K;

    typedef enum logic {frm_idle, frm_shift} ddsc_frame_e;

endpackage

/* verif/ddsc_host_model.sv */
// serial host model that frames command words onto the select, clock and data pins
`timescale 1ns/10ps
`default_nettype none
module ddsc_host_model (
    // serial pins
    output logic select_n,
    output logic serial_clk,
    output logic serial_din
);
    // ****************************************
    // framing, 320 ns serial clock period
    // ****************************************
    initial begin
        select_n   = 1'b1;
        serial_clk = 1'b0;
        serial_din = 1'b0;
    end
    // extra bits carry the inverted word, so a port that keeps listening would act on them
    // callers start on a rising edge, so every change lands on one as a nonblocking update
    task automatic send(input logic [15:0] word, input int nbits, input int extra, input logic idle_hi);
        int i;
        serial_clk <= idle_hi;
        #200 select_n <= 1'b0;
        for (i = 0; i < nbits + extra; i++) begin
            #160 serial_clk <= 1'b1;
            serial_din <= (i < 16) ? word[15 - i] : ~word[31 - i];
            #160 serial_clk <= 1'b0;
        end
        #160 select_n <= 1'b1;
        serial_din <= ~serial_din;
        serial_clk <= idle_hi;
        #200;
    endtask
endmodule
`default_nettype wire

/* verif/ddsc_top_test.sv */
// self-checking bench of the serial command block with its register bus
`timescale 1ns/10ps
`default_nettype none
module ddsc_top_test;
    import ddsc_pkg::*;
    // ****************************************
    // signals and design
    // ****************************************
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, select_n, serial_clk, serial_din;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, power_mode_a, power_mode_b;
    logic [9:0]  analog_output_a, analog_output_b;
    logic [9:0]  ei [2];
    logic [9:0]  eo [2];
    logic [1:0]  ep [2];
    int          err_count, checked, i, m;
    localparam logic [15:0] data_words [16] = '{16'h0ffc, 16'h1554, 16'h4aa8, 16'h5004, 16'h8000, 16'h9ffc,
        16'hd48c, 16'h2ffc, 16'h3ffc, 16'h6ffc, 16'h7ffc, 16'haffc, 16'hbffc, 16'he000, 16'hcffc, 16'hc000};
    localparam logic [2:0] targets [5] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h7};

    ddsc_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .select_n(select_n), .serial_clk(serial_clk),
        .serial_din(serial_din), .analog_output_a(analog_output_a), .analog_output_b(analog_output_b),
        .power_mode_a(power_mode_a), .power_mode_b(power_mode_b));
    ddsc_host_model host (.select_n(select_n), .serial_clk(serial_clk), .serial_din(serial_din));

    always #20 aclk = ~aclk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        // one edge between transfers, so a handshake signal is never assigned twice at once
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) begin
            err_count++;
            stop_test;
        end
        check({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic axi_read(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) begin
            err_count++;
            stop_test;
        end
        check({30'h0, rresp}, {30'h0, er});
        check(rdata, ed);
    endtask
    // expected effect of one complete word
    task automatic model(input logic [15:0] w);
        case (w[15:12])
            4'h0: eo[0] = w[11:2];
            4'h1: eo[1] = w[11:2];
            4'h4: ei[0] = w[11:2];
            4'h5: ei[1] = w[11:2];
            4'h8: eo[0] = ei[0];
            4'h9: eo[1] = ei[1];
            4'hc: begin
                ei = '{w[11:2], w[11:2]};
                eo = ei;
            end
            4'hd: ei = '{w[11:2], w[11:2]};
            4'he: eo = ei;
            4'hf: begin
                if (w[4:2] == 3'h0 || w[4:2] == 3'h4) ep[0] = w[1:0];
                if (w[4:2] == 3'h1 || w[4:2] == 3'h4) ep[1] = w[1:0];
            end
            default: ;
        endcase
    endtask
    task automatic check_outs;
        @(posedge aclk);
        check({22'h0, analog_output_a}, {22'h0, eo[0]});
        check({22'h0, analog_output_b}, {22'h0, eo[1]});
        check({30'h0, power_mode_a}, {30'h0, ep[0]});
        check({30'h0, power_mode_b}, {30'h0, ep[1]});
    endtask
    task automatic cmd(input logic [15:0] w, input logic idle_hi);
        model(w);
        host.send(w, 16, 0, idle_hi);
        check_outs;
        axi_read(OFS_CHAN_A, {6'h0, ei[0], 6'h0, eo[0]}, RESP_OKAY);
        axi_read(OFS_CHAN_B, {6'h0, ei[1], 6'h0, eo[1]}, RESP_OKAY);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        ei = '{CODE_RST, CODE_RST};
        eo = ei;
        ep = '{PWR_100K, PWR_100K};
        check_outs;
        axi_read(OFS_STATUS, 32'h1e, RESP_OKAY);
        axi_read(OFS_CHAN_A, 32'h0, RESP_OKAY);
    endtask
    task automatic t_data;
        for (i = 0; i < 16; i++) cmd(data_words[i], i[0]);
    endtask
    task automatic t_power;
        for (i = 0; i < 5; i++) begin
            for (m = 0; m < 4; m++) begin
                cmd({4'hf, 7'h55, targets[i], m[1:0]}, m[0]);
            end
        end
        // power-down settling before the next output register write
        repeat (200) @(posedge aclk);
    endtask
    task automatic t_frame;
        host.send(16'h0154, 15, 0, 1'b0);
        check_outs;
        model(16'h1ab8);
        host.send(16'h1ab8, 16, 16, 1'b1);
        check_outs;
    endtask
    task automatic t_bus;
        axi_write(5'h10, 32'h0, RESP_SLVERR);
        axi_read(5'h14, 32'h0, RESP_SLVERR);
        axi_write(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
        axi_read(OFS_STATUS, {27'h0, ep[1], ep[0], 1'b0}, RESP_OKAY);
        axi_write(OFS_CTRL, 32'h0, RESP_OKAY);
        host.send(16'h0aa8, 16, 0, 1'b0);
        check_outs;
        axi_write(OFS_CTRL, 32'h1, RESP_OKAY);
        axi_read(OFS_CTRL, 32'h1, RESP_OKAY);
        cmd(16'h0aa8, 1'b0);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 5'h0;
        araddr = 5'h0;
        wdata = 32'h0;
        err_count = 0;
        checked = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_data;
        t_power;
        t_frame;
        t_bus;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        stop_test;
    end
endmodule
`default_nettype wire
